// ### usb_irq_device.sv
// Purpose: usb interrupt status and mask registers with the single usb interrupt request
// Assumes: endpoint flags are levels and bus events one-cycle pulses, all on hclk
// Notes: register answers come one cycle after the request
//
// How it works
// - endpoint enable bits gate endpoint status onto irq
// - enable bit 3 read-only, reads one
// - software writes reserved fields as zero
// - endpoint enable bit map per status flag
// - bus reset sets bus status bit 15
// - suspend sets bus status bit 14
// - resume sets bus status bit 13
// - software clears resume flag after soft reset
// - bus status bits sticky, cleared by writing zero
// - armed frame match sets bit 3
// - position count load sets bit 2
// - frame start seen or synthesized sets bit 1
// - frame number received or previous plus one
// - missed frame start flag six usb clocks late
// - bus enable bits gate bus status onto irq
// - software routes interrupt channel two to usb
// - software reads status to find source
// - endpoint status bit 3 is bus status gated by bus enable
// - endpoint status bits 11..4 and 2..0 mirror endpoint flags
//
// Added by the designer: the AHB-Lite register port.
module usb_irq_device (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  usb_irq_if.device_end bus, // register port toward the controller
  input wire logic [7:0] ep_data_flags, // endpoint d..a status/activity, status bits 11..4
  input wire logic [2:0] ctrl_flags, // irq-ep activity, ctrl command, ctrl activity
  input wire logic bus_reset_evt, // pulse: host reset the bus
  input wire logic suspend_evt, // pulse: suspend detected
  input wire logic resume_evt, // pulse: resume detected
  input wire logic pos_update_evt, // pulse: position count register loaded
  input wire logic sof_expected, // pulse: frame start due now
  input wire logic sof_received, // pulse: frame start packet seen
  input wire logic [usb_irq_pkg::FRAME_W-1:0] sof_frame // frame number in that packet
);

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
    logic [15:0] ep_enable;
    logic [15:0] bus_status;
    logic [15:0] bus_enable;
    logic [usb_irq_pkg::FRAME_W-1:0] match;
    logic armed;
    logic irq;
  } device_t;

  device_t s;
  device_t next_s;
  logic [usb_irq_pkg::FRAME_W-1:0] frame_number;
  logic frame_start_generated_flag;
  logic sof_missed;
  logic [15:0] ep_status;
  logic [15:0] set_bits;
  logic [15:0] keep_bits;
  logic other_int;
  logic wr_hit;

  usb_sof_tracker usb_sof_tracker_i (
    .hclk(hclk),
    .hresetn(hresetn),
    .sof_expected(sof_expected),
    .sof_received(sof_received),
    .sof_frame(sof_frame),
    .frame_number(frame_number),
    .frame_start_generated_flag(frame_start_generated_flag),
    .sof_missed(sof_missed)
  );

  always_comb begin
    next_s = s;
    wr_hit = bus.sel && bus.wr;
    other_int = |(s.bus_status & s.bus_enable);
    ep_status = {4'h0, ep_data_flags, other_int, ctrl_flags};

    set_bits = '0;
    set_bits[usb_irq_pkg::BIT_BUS_RESET] = bus_reset_evt;
    set_bits[usb_irq_pkg::BIT_SUSPEND] = suspend_evt;
    set_bits[usb_irq_pkg::BIT_RESUME] = resume_evt;
    // frame_number and frame_start_generated_flag change on the same edge, so the compare sees the new frame
    set_bits[usb_irq_pkg::BIT_FRAME_MATCH] = s.armed && frame_start_generated_flag && (frame_number >= s.match);
    set_bits[usb_irq_pkg::BIT_POS_UPDATE] = pos_update_evt;
    set_bits[usb_irq_pkg::BIT_FRAME_START_GENERATED_FLAG] = frame_start_generated_flag;
    set_bits[usb_irq_pkg::BIT_SOF_MISSED] = sof_missed;

    // writing one keeps a flag, writing zero clears it; a same-cycle event still wins
    keep_bits = 16'hffff;
    if (wr_hit && bus.addr == usb_irq_pkg::OFS_BUS_STATUS) begin
      keep_bits = bus.wdata;
    end
    next_s.bus_status = ((s.bus_status & keep_bits) | set_bits) & usb_irq_pkg::BUS_DEFINED_BITS;

    // a match disarms until the next write of the match value
    if (set_bits[usb_irq_pkg::BIT_FRAME_MATCH]) begin
      next_s.armed = 1'b0;
    end

    if (wr_hit) begin
      if (bus.addr == usb_irq_pkg::OFS_EP_ENABLE) begin
        next_s.ep_enable = (bus.wdata & usb_irq_pkg::EP_ENABLE_WRITABLE) | usb_irq_pkg::EP_ENABLE_RESET;
      end else if (bus.addr == usb_irq_pkg::OFS_BUS_ENABLE) begin
        next_s.bus_enable = bus.wdata & usb_irq_pkg::BUS_DEFINED_BITS;
      end else if (bus.addr == usb_irq_pkg::OFS_FRAME_MATCH) begin
        next_s.match = bus.wdata[usb_irq_pkg::FRAME_W-1:0];
        next_s.armed = 1'b1;
      end
    end

    // reads: unmapped offsets and every write answer with zero data
    next_s.ack = bus.sel;
    next_s.rdata = '0;
    if (bus.sel && !bus.wr) begin
      if (bus.addr == usb_irq_pkg::OFS_EP_STATUS) begin
        next_s.rdata = ep_status;
      end else if (bus.addr == usb_irq_pkg::OFS_EP_ENABLE) begin
        next_s.rdata = s.ep_enable;
      end else if (bus.addr == usb_irq_pkg::OFS_BUS_STATUS) begin
        next_s.rdata = s.bus_status;
      end else if (bus.addr == usb_irq_pkg::OFS_BUS_ENABLE) begin
        next_s.rdata = s.bus_enable;
      end else if (bus.addr == usb_irq_pkg::OFS_FRAME_NUMBER) begin
        next_s.rdata = 16'(frame_number);
      end else if (bus.addr == usb_irq_pkg::OFS_FRAME_MATCH) begin
        next_s.rdata = 16'(s.match);
      end
    end

    // the aggregate bit is left out, else a bus event would count twice
    next_s.irq = |(ep_status & s.ep_enable & usb_irq_pkg::EP_IRQ_SOURCES)
               | |(s.bus_status & s.bus_enable);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s.ack <= 1'b0;
      s.rdata <= '0;
      s.ep_enable <= usb_irq_pkg::EP_ENABLE_RESET;
      s.bus_status <= usb_irq_pkg::BUS_STATUS_RESET;
      s.bus_enable <= usb_irq_pkg::BUS_ENABLE_RESET;
      s.match <= '0;
      s.armed <= 1'b0;
      s.irq <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign bus.ack = s.ack;
  assign bus.rdata = s.rdata;
  assign bus.irq = s.irq;

endmodule : usb_irq_device

// ### usb_irq_pkg.sv
// Purpose: shared constants for the usb interrupt status and mask block and its controller
// Assumes: one 50 MHz clock; register offsets are the device's own 16-bit offsets
// Notes: host-side offsets are byte addresses on the ahb-lite slave
package usb_irq_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned USB_HZ = 12_000_000;
  // fractional divider steps, in MHz, for the usb bit-clock enable
  localparam logic [6:0] CLK_STEP = 7'(CLK_HZ / 1_000_000);
  localparam logic [6:0] USB_STEP = 7'(USB_HZ / 1_000_000);

  localparam int FRAME_W = 11;

  // device register offsets
  localparam logic [15:0] OFS_EP_STATUS = 16'h01e0;
  localparam logic [15:0] OFS_EP_ENABLE = 16'h01e2;
  localparam logic [15:0] OFS_BUS_STATUS = 16'h01e4;
  localparam logic [15:0] OFS_BUS_ENABLE = 16'h01e6;
  localparam logic [15:0] OFS_FRAME_NUMBER = 16'h01ec;
  localparam logic [15:0] OFS_FRAME_MATCH = 16'h01ee;

  // field layouts and reset values
  localparam logic [15:0] EP_ENABLE_WRITABLE = 16'h0ff7;
  localparam logic [15:0] EP_ENABLE_RESET = 16'h0008;
  localparam logic [15:0] EP_IRQ_SOURCES = 16'h0ff7;
  localparam logic [15:0] EP_DEFINED_BITS = 16'h0fff;
  localparam logic [15:0] BUS_DEFINED_BITS = 16'he00f;
  localparam logic [15:0] BUS_STATUS_RESET = 16'h0000;
  localparam logic [15:0] BUS_ENABLE_RESET = 16'h0000;
  localparam int AGGREGATE_BIT = 3;
  localparam int BIT_BUS_RESET = 15;
  localparam int BIT_SUSPEND = 14;
  localparam int BIT_RESUME = 13;
  localparam int BIT_FRAME_MATCH = 3;
  localparam int BIT_POS_UPDATE = 2;
  localparam int BIT_FRAME_START_GENERATED_FLAG = 1;
  localparam int BIT_SOF_MISSED = 0;

  // missed frame start: grace in usb clocks, flag raised one usb clock later
  localparam logic [2:0] SOF_GRACE_TICKS = 3'd5;
  localparam logic [2:0] SOF_MISS_TICKS = SOF_GRACE_TICKS + 3'd1;

  // controller registers, byte addresses
  localparam logic [7:0] HOST_OFS_CTRL = 8'h00;
  localparam logic [7:0] HOST_OFS_ADDR = 8'h04;
  localparam logic [7:0] HOST_OFS_WDATA = 8'h08;
  localparam logic [7:0] HOST_OFS_RDATA = 8'h0c;
  localparam logic [7:0] HOST_OFS_STATUS = 8'h10;
  localparam logic [7:0] HOST_OFS_CHANNEL = 8'h14;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_WRITE_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_IRQ_BIT = 1;
  localparam int CHAN_ENABLE_BIT = 0;
  localparam int CHAN_SOURCE_BIT = 1;
  localparam logic [1:0] CHANNEL_RESET = 2'h0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {HOST_IDLE, HOST_ISSUE, HOST_WAIT} host_state_t;

endpackage : usb_irq_pkg

// ### usb_irq_if.sv
// Purpose: register port between the usb interrupt block and its controller
// Assumes: both ends on hclk; sel is a one-cycle request, ack a one-cycle answer
// Notes: irq is the single usb interrupt request level
interface usb_irq_if;
  logic sel;
  logic wr;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic ack;
  logic irq;

  modport device_end (input sel, input wr, input addr, input wdata, output rdata, output ack, output irq);
  modport host_end (output sel, output wr, output addr, output wdata, input rdata, input ack, input irq);
endinterface : usb_irq_if

// ### usb_sof_tracker.sv
// Purpose: frame number keeping and missed frame start detection
// Assumes: sof_expected marks the time a frame start is due
// Notes: usb bit clock is an enable pulse from a fractional divider of hclk
module usb_sof_tracker (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic sof_expected, // pulse: frame start now due
  input wire logic sof_received, // pulse: frame start packet seen
  input wire logic [usb_irq_pkg::FRAME_W-1:0] sof_frame, // frame number in that packet
  output logic [usb_irq_pkg::FRAME_W-1:0] frame_number, // current frame number
  output logic frame_start_generated_flag, // pulse: frame start seen or synthesized
  output logic sof_missed // pulse: frame start missed
);

  typedef struct packed {
    logic [6:0] acc;
    logic tick;
    logic waiting;
    logic [2:0] count;
    logic [usb_irq_pkg::FRAME_W-1:0] frame;
    logic gen;
    logic missed;
  } tracker_t;

  tracker_t s;
  tracker_t next_s;
  logic [7:0] sum;

  always_comb begin
    next_s = s;
    next_s.gen = 1'b0;
    next_s.missed = 1'b0;
    sum = {1'b0, s.acc} + {1'b0, usb_irq_pkg::USB_STEP};
    // 12 of every 50 system clocks carry a usb clock tick
    if (sum >= {1'b0, usb_irq_pkg::CLK_STEP}) begin
      next_s.acc = 7'(sum - {1'b0, usb_irq_pkg::CLK_STEP});
      next_s.tick = 1'b1;
    end else begin
      next_s.acc = sum[6:0];
      next_s.tick = 1'b0;
    end
    if (sof_received) begin
      next_s.frame = sof_frame;
      next_s.gen = 1'b1;
      next_s.waiting = 1'b0;
    end else if (sof_expected) begin
      next_s.waiting = 1'b1;
      next_s.count = 3'd0;
    end else if (s.waiting && s.tick) begin
      if (s.count == usb_irq_pkg::SOF_MISS_TICKS - 3'd1) begin
        next_s.missed = 1'b1;
        next_s.gen = 1'b1;
        next_s.frame = s.frame + 1'b1;
        next_s.waiting = 1'b0;
      end else begin
        next_s.count = s.count + 3'd1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign frame_number = s.frame;
  assign frame_start_generated_flag = s.gen;
  assign sof_missed = s.missed;

endmodule : usb_sof_tracker

// ### usb_irq_host.sv
// Purpose: controller end: ahb-lite register slave driving the usb interrupt register port
// Assumes: single word transfers only; zero wait states
// Notes: one device access in flight at a time; start is ignored while busy
module usb_irq_host (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // ahb slave select
  input wire logic [31:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size, word only
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb bus ready
  output logic [31:0] hrdata, // ahb read data
  output logic hreadyout, // ahb slave ready
  output logic hresp, // ahb response, always okay
  output logic cpu_irq, // usb interrupt after channel two routing
  usb_irq_if.host_end bus // register port toward the device
);

  typedef struct packed {
    logic phase_wr;
    logic [7:0] phase_addr;
    logic [31:0] hrdata;
    logic cpu_irq;
    usb_irq_pkg::host_state_t st;
    logic sel;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [1:0] chan;
  } host_t;

  host_t s;
  host_t next_s;

  function automatic logic [15:0] defined_bits(input logic [15:0] a);
    if (a == usb_irq_pkg::OFS_EP_ENABLE) begin
      return usb_irq_pkg::EP_DEFINED_BITS;
    end else if (a == usb_irq_pkg::OFS_BUS_STATUS || a == usb_irq_pkg::OFS_BUS_ENABLE) begin
      return usb_irq_pkg::BUS_DEFINED_BITS;
    end
    return 16'hffff;
  endfunction : defined_bits

  always_comb begin
    next_s = s;
    next_s.phase_wr = 1'b0;
    next_s.sel = 1'b0;

    if (s.phase_wr) begin
      if (s.phase_addr == usb_irq_pkg::HOST_OFS_ADDR) begin
        next_s.addr = hwdata[15:0];
      end else if (s.phase_addr == usb_irq_pkg::HOST_OFS_WDATA) begin
        next_s.wdata = hwdata[15:0];
      end else if (s.phase_addr == usb_irq_pkg::HOST_OFS_CHANNEL) begin
        next_s.chan = hwdata[1:0];
      end else if (s.phase_addr == usb_irq_pkg::HOST_OFS_CTRL) begin
        if (hwdata[usb_irq_pkg::CTRL_START_BIT] && s.st == usb_irq_pkg::HOST_IDLE) begin
          next_s.wr = hwdata[usb_irq_pkg::CTRL_WRITE_BIT];
          next_s.st = usb_irq_pkg::HOST_ISSUE;
        end
      end
    end

    case (s.st)
      usb_irq_pkg::HOST_ISSUE: begin
        next_s.sel = 1'b1;
        next_s.wdata = s.wdata & defined_bits(s.addr);
        next_s.st = usb_irq_pkg::HOST_WAIT;
      end
      usb_irq_pkg::HOST_WAIT: begin
        if (bus.ack) begin
          if (!s.wr) begin
            next_s.rdata = bus.rdata;
          end
          next_s.st = usb_irq_pkg::HOST_IDLE;
        end
      end
      default: begin
      end
    endcase

    if (hsel && hready && htrans[1] && hsize == usb_irq_pkg::HSIZE_WORD) begin
      if (hwrite) begin
        next_s.phase_wr = 1'b1;
        next_s.phase_addr = haddr[7:0];
      end else if (haddr[7:0] == usb_irq_pkg::HOST_OFS_ADDR) begin
        next_s.hrdata = {16'h0, s.addr};
      end else if (haddr[7:0] == usb_irq_pkg::HOST_OFS_WDATA) begin
        next_s.hrdata = {16'h0, s.wdata};
      end else if (haddr[7:0] == usb_irq_pkg::HOST_OFS_RDATA) begin
        next_s.hrdata = {16'h0, s.rdata};
      end else if (haddr[7:0] == usb_irq_pkg::HOST_OFS_STATUS) begin
        next_s.hrdata = {30'h0, bus.irq, s.st != usb_irq_pkg::HOST_IDLE};
      end else if (haddr[7:0] == usb_irq_pkg::HOST_OFS_CHANNEL) begin
        next_s.hrdata = {30'h0, s.chan};
      end else begin
        next_s.hrdata = 32'h0;
      end
    end

    // the line reaches the processor only if channel two is enabled and set to usb
    next_s.cpu_irq = bus.irq && s.chan[usb_irq_pkg::CHAN_ENABLE_BIT] && s.chan[usb_irq_pkg::CHAN_SOURCE_BIT];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.st <= usb_irq_pkg::HOST_IDLE;
      s.chan <= usb_irq_pkg::CHANNEL_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign hrdata = s.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign cpu_irq = s.cpu_irq;
  assign bus.sel = s.sel;
  assign bus.wr = s.wr;
  assign bus.addr = s.addr;
  assign bus.wdata = s.wdata;

endmodule : usb_irq_host

// ### usb_irq_sva.sv
// Purpose: concurrent checks on the register port between the usb interrupt block and its controller
// Assumes: one clock; the controller issues one access at a time
// Notes: enables are tracked from writes seen on the port, not read from inside the device
module usb_irq_sva (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic sel, // request
  input wire logic wr, // direction
  input wire logic [15:0] addr, // register offset
  input wire logic [15:0] wdata, // write data
  input wire logic [15:0] rdata, // read data
  input wire logic ack, // answer
  input wire logic irq // usb interrupt request
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] a_q, m1, m2, seen;
  logic w_q;
  logic [1:0] quiet;
  wire rd_ack = ack && !w_q;
  wire rd_m1 = rd_ack && a_q == usb_irq_pkg::OFS_EP_ENABLE;
  wire rd_m2 = rd_ack && a_q == usb_irq_pkg::OFS_BUS_ENABLE;
  wire rd_st = rd_ack && a_q == usb_irq_pkg::OFS_BUS_STATUS;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_q <= 16'h0000;
      w_q <= 1'b0;
      m1 <= usb_irq_pkg::EP_ENABLE_RESET;
      m2 <= 16'h0000;
      seen <= 16'h0000;
      quiet <= 2'd0;
    end else begin
      if (sel) begin
        a_q <= addr;
        w_q <= wr;
      end
      if (sel && wr && addr == usb_irq_pkg::OFS_EP_ENABLE) begin
        m1 <= wdata;
      end
      if (sel && wr && addr == usb_irq_pkg::OFS_BUS_ENABLE) begin
        m2 <= wdata;
      end
      // any write of bus status may clear bits, so forget what was seen
      if (sel && wr && addr == usb_irq_pkg::OFS_BUS_STATUS) begin
        seen <= 16'h0000;
      end else if (rd_st) begin
        seen <= rdata;
      end
      // margin of three cycles covers the registered mask and irq
      if (((m1 & usb_irq_pkg::EP_IRQ_SOURCES) | (m2 & usb_irq_pkg::BUS_DEFINED_BITS)) != 16'h0000) begin
        quiet <= 2'd0;
      end else if (quiet != 2'd3) begin
        quiet <= quiet + 2'd1;
      end
    end
  end
  chk_ack_after_sel: assert property (sel |=> ack && !sel)
    else $error("no single answer one cycle after request");
  chk_ack_has_cause: assert property (ack |-> $past(sel))
    else $error("answer without request");
  chk_enable_fixed_bit: assert property (rd_m1 |-> rdata[3] && rdata[15:12] == 4'h0)
    else $error("endpoint enable bit 3 not one or reserved bits set");
  chk_enable_readback: assert property (rd_m1 |-> rdata == ((m1 & usb_irq_pkg::EP_ENABLE_WRITABLE) | 16'h0008))
    else $error("endpoint enable readback wrong");
  chk_bus_mask_readback: assert property (rd_m2 |-> rdata == (m2 & usb_irq_pkg::BUS_DEFINED_BITS))
    else $error("bus enable readback wrong");
  chk_status_sticky: assert property (rd_st |-> (rdata & seen) == seen)
    else $error("bus status bit lost without a write");
  chk_status_reserved: assert property (rd_st |-> rdata[12:4] == 9'h000)
    else $error("bus status reserved bits set");
  chk_masked_quiet: assert property (quiet == 2'd3 |-> !irq)
    else $error("irq raised with all enables clear");
  chk_write_no_data: assert property (ack && w_q |-> rdata == 16'h0000)
    else $error("read data on a write answer");
  chk_frame_reserved: assert property (rd_ack && a_q == usb_irq_pkg::OFS_FRAME_NUMBER |-> rdata[15:11] == 5'h00)
    else $error("frame number reserved bits set");
  cover property (rd_st && rdata != 16'h0000);
  cover property ($rose(irq));
  cover property (sel && wr && addr == usb_irq_pkg::OFS_FRAME_MATCH);
endmodule : usb_irq_sva

// ### usb_interrupt_status_mask_bench.sv
// Purpose: self-checking bench for the usb interrupt block and its ahb controller
// Assumes: 50 MHz hclk; zero wait ahb slave
// Notes: device registers are reached through the controller mailbox
module usb_interrupt_status_mask_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, sof_expected, sof_received, hreadyout, hresp, cpu_irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [10:0] src, sof_frame;
  logic [3:0] evt;
  int mismatches, compares;
  usb_irq_if usb_irq_if_i ();
  usb_irq_device usb_irq_device_i (.hclk(hclk), .hresetn(hresetn), .bus(usb_irq_if_i.device_end),
    .ep_data_flags(src[10:3]), .ctrl_flags(src[2:0]), .bus_reset_evt(evt[3]), .suspend_evt(evt[2]),
    .resume_evt(evt[1]), .pos_update_evt(evt[0]), .sof_expected(sof_expected),
    .sof_received(sof_received), .sof_frame(sof_frame));
  usb_irq_host usb_irq_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cpu_irq(cpu_irq), .bus(usb_irq_if_i.host_end));
  usb_irq_sva usb_irq_sva_i (.hclk(hclk), .hresetn(hresetn), .sel(usb_irq_if_i.sel), .wr(usb_irq_if_i.wr),
    .addr(usb_irq_if_i.addr), .wdata(usb_irq_if_i.wdata), .rdata(usb_irq_if_i.rdata),
    .ack(usb_irq_if_i.ack), .irq(usb_irq_if_i.irq));
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      final_report();
    end
  endtask : wait_ready
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask : ahb
  // one device access through the mailbox; rd ends holding the returned word
  task automatic dev(input logic w, input logic [15:0] ofs, input logic [15:0] d);
    int n;
    ahb(1'b1, usb_irq_pkg::HOST_OFS_ADDR, {16'h0000, ofs});
    ahb(1'b1, usb_irq_pkg::HOST_OFS_WDATA, {16'h0000, d});
    ahb(1'b1, usb_irq_pkg::HOST_OFS_CTRL, {30'h00000000, w, 1'b1});
    n = 0;
    do begin
      ahb(1'b0, usb_irq_pkg::HOST_OFS_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 20);
    if (rd[0] !== 1'b0) begin
      mismatches++;
      final_report();
    end
    ahb(1'b0, usb_irq_pkg::HOST_OFS_RDATA, 32'h0);
  endtask : dev
  task automatic rd_chk(input logic [15:0] ofs, input logic [15:0] exp);
    dev(1'b0, ofs, 16'h0000);
    chk(rd[15:0], exp);
  endtask : rd_chk
  task automatic irq_chk(input logic raw, input logic cpu);
    ahb(1'b0, usb_irq_pkg::HOST_OFS_STATUS, 32'h0);
    chk({15'h0000, rd[1]}, {15'h0000, raw});
    chk({15'h0000, cpu_irq}, {15'h0000, cpu});
    chk({15'h0000, hresp}, 16'h0000);
  endtask : irq_chk
  task automatic pulse_evt(input int k);
    @(posedge hclk);
    evt <= 4'(1 << k);
    @(posedge hclk);
    evt <= 4'h0;
  endtask : pulse_evt
  task automatic sof_rx(input logic [10:0] f, input logic missed);
    @(posedge hclk);
    sof_expected <= missed;
    sof_received <= !missed;
    sof_frame <= f;
    @(posedge hclk);
    sof_expected <= 1'b0;
    sof_received <= 1'b0;
  endtask : sof_rx
  initial begin
    int k;
    logic [15:0] b;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = usb_irq_pkg::HSIZE_WORD;
    hwdata = 32'h0;
    src = 11'h000;
    evt = 4'h0;
    sof_expected = 1'b0;
    sof_received = 1'b0;
    sof_frame = 11'h000;
    mismatches = 0;
    compares = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(16'h01e2, 16'h0008);
    rd_chk(16'h01e4, 16'h0000);
    rd_chk(16'h01e6, 16'h0000);
    rd_chk(16'h01f8, 16'h0000);
    dev(1'b1, 16'h01e2, 16'hffff);
    rd_chk(16'h01e2, 16'h0fff);
    ahb(1'b0, 8'h04, 32'h0);
    chk(rd[15:0], 16'h01e2);
    ahb(1'b0, 8'h14, 32'h0);
    chk(rd[15:0], 16'h0000);
    src <= 11'h001;
    irq_chk(1'b1, 1'b0);
    ahb(1'b1, 8'h14, 32'h1);
    irq_chk(1'b1, 1'b0);
    ahb(1'b1, 8'h14, 32'h3);
    irq_chk(1'b1, 1'b1);
    dev(1'b1, 16'h01e2, 16'h0000);
    irq_chk(1'b0, 1'b0);
    rd_chk(16'h01e2, 16'h0008);
    // one source at a time; src is driven once per time step
    for (k = 0; k < 11; k++) begin
      b = 16'(1) << (k < 3 ? k : k + 1);
      src <= 11'(1) << k;
      irq_chk(1'b0, 1'b0);
      rd_chk(16'h01e0, b);
      dev(1'b1, 16'h01e2, b);
      irq_chk(1'b1, 1'b1);
      dev(1'b1, 16'h01e2, 16'h0000);
    end
    src <= 11'h000;
    for (k = 0; k < 4; k++) begin
      b = 16'(1) << (k == 0 ? 2 : k + 12);
      pulse_evt(k);
      rd_chk(16'h01e4, b);
      irq_chk(1'b0, 1'b0);
      dev(1'b1, 16'h01e6, b);
      irq_chk(1'b1, 1'b1);
      rd_chk(16'h01e0, 16'h0008);
      dev(1'b1, 16'h01e4, 16'hffff);
      rd_chk(16'h01e4, b);
      dev(1'b1, 16'h01e4, 16'h0000);
      rd_chk(16'h01e4, 16'h0000);
      irq_chk(1'b0, 1'b0);
      dev(1'b1, 16'h01e6, 16'h0000);
    end
    dev(1'b1, 16'h01ee, 16'h0007);
    rd_chk(16'h01ee, 16'h0007);
    sof_rx(11'h006, 1'b0);
    rd_chk(16'h01ec, 16'h0006);
    rd_chk(16'h01e4, 16'h0002);
    dev(1'b1, 16'h01e4, 16'h0000);
    // packet a few hclk cycles after it fell due, well inside the five-tick grace
    sof_rx(11'h000, 1'b1);
    repeat (4) @(posedge hclk);
    sof_rx(11'h007, 1'b0);
    rd_chk(16'h01e4, 16'h000a);
    dev(1'b1, 16'h01e4, 16'h0000);
    dev(1'b1, 16'h01e6, 16'h0003);
    sof_rx(11'h000, 1'b1);
    repeat (30) @(posedge hclk);
    rd_chk(16'h01e4, 16'h0003);
    rd_chk(16'h01ec, 16'h0008);
    irq_chk(1'b1, 1'b1);
    final_report();
  end
endmodule : usb_interrupt_status_mask_bench
